// >>> core/ftd_pkg.sv
package ftd_pkg;
   // clock rate and derived cycle counts
   localparam int CLK_PERIOD_NS = 25;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
   localparam int WAKE_US       = 500;
   localparam int WAKE_CYC      = (WAKE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // acquisition cadence, drift and max-on periods in ms ticks
   localparam int SLEEP_FAST_MS = 16;
   localparam int SLEEP_SLOW_MS = 64;
   localparam int DRIFT_NEG_MS  = 3000;
   localparam int DRIFT_POS_MS  = 1000;
   localparam int MAXON_MS      = 30000;
   // detection figures in counts
   localparam int SIG_W         = 12;
   localparam int BURST_MAX     = 2048;
   localparam int THR_ENTER     = 10;
   localparam int THR_EXIT      = 8;
   localparam int INTEG_LIMIT   = 5;
   localparam int CAL_ACQ       = 4;
   localparam int CAL_SHIFT     = 2;
   localparam int MIN_SIG       = 4;
   // charge-transfer pulse spacing and its spread
   localparam int CT_BASE_CYC   = 40;
   localparam int SPREAD_PERMIL = 75;
   localparam int CT_SPREAD_CYC = CT_BASE_CYC * SPREAD_PERMIL / 1000;
   // debug serial half period
   localparam int DBG_HALF_CYC  = 20;
   // acquisition sequencer states
   typedef enum logic [1:0] {ST_WAKE, ST_BURST, ST_EVAL, ST_SLEEP} ftd_state_e;
endpackage

// >>> core/ftd_spread.sv
`timescale 1ns/1ps
module ftd_spread #(
   parameter int BASE = ftd_pkg::CT_BASE_CYC,
   parameter int SPR  = ftd_pkg::CT_SPREAD_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic run,
   output logic      ct
);
   localparam int CW = $clog2(BASE + SPR + 1);

   logic [CW-1:0]        cnt;
   logic signed [CW+1:0] ofs;
   logic                 up;

   // period swept as a triangle between base-spread and base+spread
   wire signed [CW+1:0] per_s  = (CW+2)'(BASE) + ofs;
   wire [CW-1:0]        period = CW'(per_s);
   wire                 last   = cnt == CW'(period - 1'h1);

   // pulse divider with a stepped period
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= '0;
         ofs <= '0;
         up  <= 1'h1;
         ct  <= 1'h0;
      end else begin
         ct <= run && last;
         if (!run) begin
            cnt <= '0;
         end else if (last) begin
            cnt <= '0;
            ofs <= up ? ofs + (CW+2)'(1) : ofs - (CW+2)'(1);
            if (up && ofs >= (CW+2)'(SPR - 1)) up <= 1'h0;
            if (!up && ofs <= (CW+2)'(1 - SPR)) up <= 1'h1;
         end else begin
            cnt <= cnt + 1'h1;
         end
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_spread_band: assert property (
      run && last |-> period >= CW'(BASE - SPR) && period <= CW'(BASE + SPR))
      else $error("pulse period left the spread band");
endmodule

// >>> core/ftd_chan.sv
`timescale 1ns/1ps
module ftd_chan #(
   parameter int SIG_W    = ftd_pkg::SIG_W,
   parameter int MAXON_MS = ftd_pkg::MAXON_MS
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   input  wire logic             eval,
   input  wire logic             cal,
   input  wire logic             cal_last,
   input  wire logic [SIG_W-1:0] sig,
   input  wire logic             drift_neg,
   input  wire logic             drift_pos,
   input  wire logic             drift_hold,
   input  wire logic             ms_tick,
   output logic                  det,
   output logic                  en
);
   localparam int OW = $clog2(MAXON_MS + 1);

   logic [SIG_W-1:0] ref_lvl;
   logic [2:0]       integ;
   logic [SIG_W+1:0] cal_sum;
   logic [OW-1:0]    on_ms;

   // signed change of the signal below the reference
   wire signed [SIG_W:0] delta   = $signed({1'h0, ref_lvl}) - $signed({1'h0, sig});
   wire                  above   = delta >= (SIG_W+1)'(ftd_pkg::THR_ENTER);
   wire                  below   = delta < (SIG_W+1)'(ftd_pkg::THR_EXIT);
   wire                  timeout = det && ms_tick && on_ms == OW'(MAXON_MS - 1);
   wire [SIG_W+1:0]      cal_tot = cal_sum + (SIG_W+2)'(sig);
   wire                  measure = eval && !cal && en;
   wire                  drift   = measure && !drift_hold;

   // detection time counter, cleared whenever the key is out of detect
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) on_ms <= '0;
      else if (!det) on_ms <= '0;
      else if (ms_tick) on_ms <= on_ms + 1'h1;
   end

   // calibration, integrator, hysteresis and drift
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ref_lvl <= '0;
         integ   <= '0;
         cal_sum <= '0;
         det     <= 1'h0;
         en      <= 1'h0;
      end else if (timeout) begin
         ref_lvl <= sig;
         det     <= 1'h0;
         integ   <= '0;
      end else if (eval && cal) begin
         cal_sum <= cal_last ? '0 : cal_tot;
         if (cal_last) begin
            ref_lvl <= SIG_W'(cal_tot >> ftd_pkg::CAL_SHIFT);
            en      <= sig >= SIG_W'(ftd_pkg::MIN_SIG);
         end
      end else if (measure) begin
         if (det) begin
            if (below) begin
               det   <= 1'h0;
               integ <= '0;
            end
         end else if (above) begin
            integ <= integ + 1'h1;
            if (integ == 3'(ftd_pkg::INTEG_LIMIT - 1)) det <= 1'h1;
         end else begin
            integ <= '0;
         end
         if (drift && drift_neg && sig < ref_lvl) ref_lvl <= ref_lvl - 1'h1;
         else if (drift && drift_pos && sig > ref_lvl) ref_lvl <= ref_lvl + 1'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_entry_thr: assert property (
      measure && !det && !above |=> !det && integ == 3'h0)
      else $error("key entered or integrated below threshold");
   a_det_five: assert property (
      $rose(det) |-> $past(integ) == 3'(ftd_pkg::INTEG_LIMIT - 1) && $past(above))
      else $error("detect without full integration");
   a_exit_hyst: assert property (
      measure && det && !below && !timeout |=> det)
      else $error("key released above exit level");
   a_release_clr: assert property (
      measure && det && below && !timeout |=> !det && integ == 3'h0)
      else $error("release did not clear integrator");
   a_drift_hold: assert property (
      eval && drift_hold && !cal && !timeout |=> ref_lvl == $past(ref_lvl))
      else $error("reference moved while a key is in detect");
   a_disabled_quiet: assert property (
      !en |-> !det)
      else $error("disabled channel in detect");
   a_maxon_recal: assert property (
      timeout |=> !det && ref_lvl == $past(sig))
      else $error("max-on timeout did not recalibrate");
endmodule

// >>> core/ftd_touch.sv
`timescale 1ns/1ps
// Contract
// - a channel is above threshold when signal is 10 counts below reference
// - a key in detect releases only when the change falls below 8 counts or its 30 s max-on timeout ends
// - per-key integrator needs 5 consecutive above-threshold acquisitions to detect
// - a burst takes at most 2048 pulses; the pulse count is the signal
// - each channel keeps its own signal, reference, integrator and detect state
// - with suppression on, at most one key is reported at any time
// - with suppression off, any combination of keys may be in detect
// - suppression strap high enables suppression, low disables it
// - drift moves each reference slowly toward its raw signal
// - drift is held on all channels while any key is in detect
// - drift steps downward every 3 s and upward every 1 s
// - charge pulse spacing is spread by plus or minus 7.5 percent
// - a detect lasting 30 s recalibrates the key and clears it
// - a channel without sample capacitor is disabled and never reported
// - four open-drain outputs show each key's debounced touched state
// - in debug mode output zero is clock and output one is data
// - slow mode spaces bursts further apart than fast mode
// - an output is driven low while touched, released otherwise
// - speed strap high selects fast mode, low selects slow mode
// - sleep between acquisitions is 16 ms fast, 64 ms slow
// - after each wake the device waits 500 us before acquiring
module ftd_touch #(
   parameter int MS_CYC       = ftd_pkg::MS_CYC,
   parameter int WAKE_CYC     = ftd_pkg::WAKE_CYC,
   parameter int DRIFT_NEG_MS = ftd_pkg::DRIFT_NEG_MS,
   parameter int DRIFT_POS_MS = ftd_pkg::DRIFT_POS_MS,
   parameter int MAXON_MS     = ftd_pkg::MAXON_MS,
   parameter int SIG_W        = ftd_pkg::SIG_W
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       option_sense_suppress,
   input  wire logic       option_sense_speed,
   input  wire logic       debug_mode,
   input  wire logic [3:0] sense_trip,
   output logic            ct_pulse,
   output logic            burst_run,
   output logic            key_out_zero_oe_b,
   output logic            key_out_one_oe_b,
   output logic            key_out_two_oe_b,
   output logic            key_out_three_oe_b
);
   localparam int MW = $clog2(MS_CYC);
   localparam int WW = $clog2(WAKE_CYC);
   localparam int NW = $clog2(DRIFT_NEG_MS);
   localparam int PW = $clog2(DRIFT_POS_MS);
   localparam int DB = 4 * SIG_W;

   ftd_pkg::ftd_state_e st;

   logic [WW-1:0]    wait_cnt;
   logic [6:0]       sleep_ms;
   logic [SIG_W-1:0] pulse_cnt;
   logic [2:0]       cal_cnt;
   logic             strap_done;
   logic             adjacent_suppression;
   logic             fast;
   logic [MW-1:0]    ms_cnt;
   logic             ms_tick;
   logic [NW-1:0]    neg_ms;
   logic [PW-1:0]    pos_ms;
   logic             neg_p;
   logic             pos_p;
   logic [3:0]       trip;
   logic [3:0]       det;
   logic [3:0]       en;
   logic [3:0]       rep;
   logic [3:0]       oe_b;
   logic [SIG_W-1:0] sig_r [4];
   logic [DB-1:0]    dbg_sh;
   logic [5:0]       dbg_left;
   logic [4:0]       dbg_div;
   logic             dbg_clk;
   logic             ct_en;

   // sequencer decode
   wire       in_cal       = cal_cnt < 3'(ftd_pkg::CAL_ACQ);
   wire       cal_last     = cal_cnt == 3'(ftd_pkg::CAL_ACQ - 1);
   wire [6:0] sleep_target = fast ? 7'(ftd_pkg::SLEEP_FAST_MS)
                                  : 7'(ftd_pkg::SLEEP_SLOW_MS);
   wire       wake_done    = st == ftd_pkg::ST_WAKE && wait_cnt == WW'(WAKE_CYC - 1);
   wire       burst_done   = st == ftd_pkg::ST_BURST && &trip;
   wire       sleep_done   = st == ftd_pkg::ST_SLEEP && ms_tick
                             && sleep_ms == sleep_target - 7'h01;
   wire       eval         = st == ftd_pkg::ST_EVAL;
   wire       burst_start  = wake_done || (eval && in_cal);
   wire       meas_eval    = eval && !in_cal;
   wire       burst_full   = pulse_cnt == SIG_W'(ftd_pkg::BURST_MAX);
   wire       any_det      = |det;

   // report selection: keep the owner key, else the lowest detecting key
   wire [3:0] keep_det = rep & det;
   wire [3:0] low_det  = det & (~det + 4'h1);
   wire [3:0] next_rep = !adjacent_suppression ? det : (|keep_det) ? keep_det : low_det;

   // drift tick and debug divider decode
   wire neg_hit  = ms_tick && neg_ms == NW'(DRIFT_NEG_MS - 1);
   wire pos_hit  = ms_tick && pos_ms == PW'(DRIFT_POS_MS - 1);
   wire dbg_half = dbg_div == 5'(ftd_pkg::DBG_HALF_CYC - 1);
   wire dbg_load = meas_eval && debug_mode;

   // output pins
   assign key_out_zero_oe_b  = oe_b[0];
   assign key_out_one_oe_b   = oe_b[1];
   assign key_out_two_oe_b   = oe_b[2];
   assign key_out_three_oe_b = oe_b[3];

   // option straps caught once after reset release
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         strap_done <= 1'h0;
         adjacent_suppression        <= 1'h0;
         fast       <= 1'h0;
      end else if (!strap_done) begin
         strap_done <= 1'h1;
         adjacent_suppression        <= option_sense_suppress;
         fast       <= option_sense_speed;
      end
   end

   // millisecond tick, restarted at each evaluation so sleep is exact
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ms_cnt  <= '0;
         ms_tick <= 1'h0;
      end else begin
         ms_tick <= !eval && ms_cnt == MW'(MS_CYC - 1); // no stray tick into sleep
         if (eval || ms_cnt == MW'(MS_CYC - 1)) ms_cnt <= '0;
         else ms_cnt <= ms_cnt + 1'h1;
      end
   end

   // acquisition sequencer: wake wait, burst, evaluate, sleep
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st       <= ftd_pkg::ST_WAKE;
         wait_cnt <= '0;
         sleep_ms <= '0;
         cal_cnt  <= '0;
      end else begin
         unique case (st)
            ftd_pkg::ST_WAKE: begin
               wait_cnt <= wake_done ? '0 : wait_cnt + 1'h1;
               if (wake_done) st <= ftd_pkg::ST_BURST;
            end
            ftd_pkg::ST_BURST: begin
               if (burst_done) st <= ftd_pkg::ST_EVAL;
            end
            ftd_pkg::ST_EVAL: begin
               st <= in_cal ? ftd_pkg::ST_BURST : ftd_pkg::ST_SLEEP;
               if (in_cal) cal_cnt <= cal_cnt + 1'h1;
            end
            ftd_pkg::ST_SLEEP: begin
               if (ms_tick) sleep_ms <= sleep_done ? '0 : sleep_ms + 1'h1;
               if (sleep_done) st <= ftd_pkg::ST_WAKE;
            end
         endcase
      end
   end

   // pulse counter of the running burst, capped at the longest burst
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) pulse_cnt <= '0;
      else if (burst_start) pulse_cnt <= '0;
      else if (st == ftd_pkg::ST_BURST && ct_en && !burst_full)
         pulse_cnt <= pulse_cnt + 1'h1;
   end

   // charge pulse timing with spread spacing
   ftd_spread u_spread (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .run     (st == ftd_pkg::ST_BURST),
      .ct      (ct_en)
   );

   // front-end strobes
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ct_pulse  <= 1'h0;
         burst_run <= 1'h0;
      end else begin
         ct_pulse  <= ct_en;
         burst_run <= st == ftd_pkg::ST_BURST;
      end
   end

   // per-channel signal capture and detection
   for (genvar i = 0; i < 4; i++) begin : g_ch
      logic             t;
      logic [SIG_W-1:0] s;

      // signal is the pulse count at the trip, or the cap if none
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            t <= 1'h0;
            s <= '0;
         end else if (burst_start) begin
            t <= 1'h0;
         end else if (st == ftd_pkg::ST_BURST && !t && (sense_trip[i] || burst_full)) begin
            t <= 1'h1;
            s <= pulse_cnt;
         end
      end

      assign trip[i]  = t;
      assign sig_r[i] = s;

      ftd_chan #(
         .SIG_W    (SIG_W),
         .MAXON_MS (MAXON_MS)
      ) u_chan (
         .clk_sys    (clk_sys),
         .rst_b      (rst_b),
         .eval       (eval),
         .cal        (in_cal),
         .cal_last   (cal_last),
         .sig        (s),
         .drift_neg  (neg_p),
         .drift_pos  (pos_p),
         .drift_hold (any_det),
         .ms_tick    (ms_tick),
         .det        (det[i]),
         .en         (en[i])
      );
   end

   // drift period timers; a pending step is held until the next evaluation
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         neg_ms <= '0;
         pos_ms <= '0;
         neg_p  <= 1'h0;
         pos_p  <= 1'h0;
      end else begin
         if (neg_hit) neg_ms <= '0;
         else if (ms_tick) neg_ms <= neg_ms + 1'h1;
         if (pos_hit) pos_ms <= '0;
         else if (ms_tick) pos_ms <= pos_ms + 1'h1;
         neg_p <= neg_hit || (neg_p && !meas_eval);
         pos_p <= pos_hit || (pos_p && !meas_eval);
      end
   end

   // debug serialiser: four signals, msb first, data moves on clock rise
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dbg_sh   <= '0;
         dbg_left <= '0;
         dbg_div  <= '0;
         dbg_clk  <= 1'h1;
      end else if (dbg_load) begin
         dbg_sh   <= {sig_r[3], sig_r[2], sig_r[1], sig_r[0]};
         dbg_left <= 6'(DB);
         dbg_div  <= '0;
         dbg_clk  <= 1'h1;
      end else if (dbg_left != 6'h00) begin
         dbg_div <= dbg_half ? '0 : dbg_div + 1'h1;
         if (dbg_half) begin
            dbg_clk <= !dbg_clk;
            if (!dbg_clk) begin
               dbg_sh   <= dbg_sh << 1;
               dbg_left <= dbg_left - 1'h1;
            end
         end
      end
   end

   // reported keys and open-drain enables, low enable pulls the pin low
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rep  <= '0;
         oe_b <= 4'hf;
      end else begin
         rep <= next_rep;
         if (debug_mode) oe_b <= {2'h3, dbg_sh[DB-1], dbg_clk};
         else oe_b <= ~rep;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_wake_exit;
      st == ftd_pkg::ST_WAKE ##1 st == ftd_pkg::ST_BURST;
   endsequence

   sequence s_sleep_exit;
      st == ftd_pkg::ST_SLEEP ##1 st == ftd_pkg::ST_WAKE;
   endsequence

   sequence s_burst_capped;
      st == ftd_pkg::ST_BURST && burst_full;
   endsequence

   a_aks_one_key: assert property (
      adjacent_suppression |-> $onehot0(rep))
      else $error("more than one key reported with suppression");
   a_free_combo: assert property (
      strap_done && !adjacent_suppression |=> rep == $past(det))
      else $error("detect pattern not passed through");
   a_out_follow: assert property (
      !debug_mode |=> oe_b == ~$past(rep))
      else $error("output enables do not follow reported keys");
   a_wake_wait: assert property (
      s_wake_exit |-> $past(wait_cnt) == WW'(WAKE_CYC - 1))
      else $error("burst started before the wake wait ended");
   a_sleep_len: assert property (
      s_sleep_exit |-> $past(sleep_ms) == $past(sleep_target) - 7'h01 && $past(ms_tick))
      else $error("sleep length wrong for speed mode");
   a_burst_end: assert property (
      s_burst_capped |-> ##[1:2] st == ftd_pkg::ST_EVAL)
      else $error("burst ran past its pulse limit");
   a_cal_quiet: assert property (
      in_cal |-> det == 4'h0)
      else $error("detect during calibration");
   a_strap_hold: assert property (
      strap_done |=> $stable(adjacent_suppression) && $stable(fast))
      else $error("strap value changed after capture");
endmodule

// >>> verif/ftd_front_model.sv
`timescale 1ns/1ps
// front-end model: counts charge strobes in a burst, trips each channel at its own target
module ftd_front_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic        ct_pulse,
   input  wire logic        burst_run,
   input  wire logic [11:0] tgt [4],
   output logic      [3:0]  sense_trip
);
   logic [11:0] n_ct;

   // count restarts while idle, since the sample caps are discharged then
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         n_ct <= 12'h000;
      end else if (!burst_run) begin
         n_ct <= 12'h000;
      end else if (ct_pulse) begin
         n_ct <= n_ct + 12'h001;
      end
   end

   // independent comparators, all low outside a burst
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         sense_trip[i] = burst_run && (n_ct >= tgt[i]);
      end
   end
endmodule

// >>> verif/ftd_touch_tb.sv
`timescale 1ns/1ps
module ftd_touch_tb;
   // short ms and max-on so the run stays small; drift kept slow so it never hides a touch
   localparam int MS_CYC   = 40;
   localparam int WAKE_CYC = 20;
   localparam int MAXON_MS = 300;

   logic        clk_sys;
   logic        rst_b;
   logic        option_sense_suppress;
   logic        option_sense_speed;
   logic        debug_mode;
   logic [3:0]  sense_trip;
   logic        ct_pulse;
   logic        burst_run;
   logic [3:0]  oe_b;
   logic [11:0] tgt [4];
   int          n_fail;
   int          samples_checked;

   ftd_touch #(.MS_CYC(MS_CYC), .WAKE_CYC(WAKE_CYC), .DRIFT_NEG_MS(1200), .DRIFT_POS_MS(400),
      .MAXON_MS(MAXON_MS), .SIG_W(12)) i_dut (
      .clk_sys              (clk_sys),
      .rst_b                (rst_b),
      .option_sense_suppress(option_sense_suppress),
      .option_sense_speed   (option_sense_speed),
      .debug_mode           (debug_mode),
      .sense_trip           (sense_trip),
      .ct_pulse             (ct_pulse),
      .burst_run            (burst_run),
      .key_out_zero_oe_b    (oe_b[0]),
      .key_out_one_oe_b     (oe_b[1]),
      .key_out_two_oe_b     (oe_b[2]),
      .key_out_three_oe_b   (oe_b[3])
   );

   ftd_front_model i_front (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .ct_pulse  (ct_pulse),
      .burst_run (burst_run),
      .tgt       (tgt),
      .sense_trip(sense_trip)
   );

   // 40 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_up(input string what);
      check(32'h0, 32'h1, what);
      finish_test();
   endtask

   // bounded wait for a burst_run level, sampled just after the edge
   task automatic wait_run(input logic v);
      int k;
      k = 0;
      while (burst_run !== v) begin
         @(posedge clk_sys);
         #1;
         k++;
         if (k > 20000) give_up("burst wait ran out");
      end
   endtask

   // let n acquisitions finish, then let the outputs settle
   task automatic wait_evals(input int n);
      repeat (n) begin
         wait_run(1'b1);
         wait_run(1'b0);
      end
      repeat (6) @(posedge clk_sys);
      #2;
   endtask

   task automatic do_reset(input logic sup, input logic spd, input logic [11:0] t3);
      rst_b = 1'b0;
      option_sense_suppress = sup;
      option_sense_speed = spd;
      debug_mode = 1'b0;
      tgt = '{12'h010, 12'h010, 12'h010, t3};
      repeat (12) @(posedge clk_sys);
      #2;
      rst_b = 1'b1;
      @(posedge clk_sys);
      #1;
      check(oe_b, 4'hf, "outputs after reset");
      check({burst_run, ct_pulse}, 2'h0, "no burst before wake wait");
      wait_evals(4);
      check(oe_b, 4'hf, "outputs after calibration");
   endtask

   // idle gap between two bursts: sleep plus wake wait
   task automatic measure_gap(input int ms);
      int n;
      wait_run(1'b1);
      wait_run(1'b0);
      n = 0;
      while (burst_run !== 1'b1 && n < 5000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      check(n >= ms * MS_CYC + WAKE_CYC && n <= ms * MS_CYC + WAKE_CYC + 12, 1, "gap");
   endtask

   task automatic scen_spread();
      int gap;
      int lo;
      int hi;
      lo = 1000;
      hi = 0;
      wait_run(1'b1);
      for (int p = 0; p < 13; p++) begin
         gap = 0;
         do begin
            @(posedge clk_sys);
            #1;
            gap++;
         end while (ct_pulse !== 1'b1 && gap < 100);
         if (p > 0) begin
            lo = (gap < lo) ? gap : lo;
            hi = (gap > hi) ? gap : hi;
         end
      end
      check(lo >= 37 && hi <= 43, 1, "strobe spacing range");
      check(lo != hi, 1, "strobe spacing varies");
   endtask

   // fast mode, no suppression: threshold, integrator, hysteresis, disabled channel, max-on
   task automatic scen_touch();
      int n;
      do_reset(1'b0, 1'b1, 12'h002);
      tgt[0] = 12'h004;
      tgt[1] = 12'h007;
      tgt[3] = 12'h001;
      wait_evals(4);
      check(oe_b, 4'hf, "four acquisitions");
      wait_evals(1);
      check(oe_b, 4'he, "fifth acquisition");
      tgt[0] = 12'h008;
      wait_evals(2);
      check(oe_b, 4'he, "change of eight holds");
      tgt[0] = 12'h009;
      wait_evals(1);
      check(oe_b, 4'hf, "change of seven releases");
      tgt[0] = 12'h004;
      wait_evals(4);
      check(oe_b, 4'hf, "new touch recounts");
      wait_evals(1);
      check(oe_b, 4'he, "new touch confirmed");
      n = 0;
      while (oe_b[0] !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > MAXON_MS * MS_CYC + 5000) give_up("max-on release missing");
      end
      check(n >= (MAXON_MS - 1) * MS_CYC, 1, "max-on too early");
      wait_evals(3);
      check(oe_b, 4'hf, "recalibrated key stays off");
   endtask

   // suppression on: only one key reported, the other takes over on release
   task automatic scen_suppress();
      do_reset(1'b1, 1'b1, 12'h010);
      tgt[0] = 12'h004;
      tgt[1] = 12'h004;
      measure_gap(16);
      scen_spread();
      wait_evals(4);
      check(oe_b, 4'he, "one key reported");
      tgt[0] = 12'h010;
      wait_evals(1);
      check(oe_b, 4'hd, "next key reported");
   endtask

   // slow mode, no suppression: two keys together, then debug outputs
   task automatic scen_slow();
      logic        seen_low;
      logic        prev_clk;
      logic [11:0] frame;
      int          n_bits;
      do_reset(1'b0, 1'b0, 12'h010);
      tgt[1] = 12'h004;
      tgt[2] = 12'h004;
      measure_gap(64);
      wait_evals(4);
      check(oe_b, 4'h9, "two keys together");
      debug_mode = 1'b1;
      wait_evals(1);
      seen_low = 1'b0;
      prev_clk = oe_b[0];
      frame = 12'h000;
      n_bits = 0;
      // data is stable on the falling debug clock; first signal out is channel three
      repeat (600) begin
         @(posedge clk_sys);
         #1;
         if (oe_b[0] === 1'b0) seen_low = 1'b1;
         if (prev_clk === 1'b1 && oe_b[0] === 1'b0 && n_bits < 12) begin
            frame = {frame[10:0], oe_b[1]};
            n_bits++;
         end
         prev_clk = oe_b[0];
      end
      check(seen_low, 1, "debug clock toggles");
      check(frame, tgt[3], "debug frame first signal");
      check(oe_b[3:2], 2'h3, "keys two and three released in debug");
   endtask

   initial begin
      n_fail = 0;
      samples_checked = 0;
      rst_b = 1'b0;
      option_sense_suppress = 1'b0;
      option_sense_speed = 1'b1;
      debug_mode = 1'b0;
      tgt = '{12'h010, 12'h010, 12'h010, 12'h010};
      scen_touch();
      scen_suppress();
      scen_slow();
      finish_test();
   end
endmodule
